// File: src/interrupt_enable_priority_wake.sv
`timescale 1ns/1ns

// Overview of operation
// - Priority bits reset to high priority.
// - Vector table base resets to 0x000008.
// - Edge select picks rising or falling edge.
// - Selected pin edge sets its flag.
// - Disabled external input raises no request.
// - Enabled external event wakes Idle or Sleep.
// - Vector taken after wake only if enabled.
// - External priority from its own priority bit.
// - Wake request ignores the global enables.
// - Wake request holds with no running clock; raising it needs clk_i.
// - Vectoring off bypasses the table order.
// - Both modes off branch to 0008h.
// - Global control layout and reset values.
// - Priority off: global enable gates all.
// - Priority on: high enable gates everything.
// - Low enable passes low-priority requests.
// - Low enable cleared blocks low only.
// - Low enable reads zero without priority.
// - Priority off treats all as high.
module interrupt_enable_priority_wake #(
   parameter int NSRC = 8
) (
   input  wire logic                            clk_i,
   input  wire logic                            rst_b_i,
   input  wire logic [irq_pkg::ADDR_W-1:0]      reg_addr_i,
   input  wire logic [irq_pkg::DATA_W-1:0]      reg_wdata_i,
   input  wire logic                            reg_wr_i,
   input  wire logic                            reg_rd_i,
   output logic      [irq_pkg::DATA_W-1:0]      reg_rdata_o,
   input  wire logic [irq_pkg::NUM_EXT-1:0]     ext_irq_pin_i,
   input  wire logic [NSRC-1:0]                 src_event_i,
   output logic                                 irq_high_o,
   output logic                                 irq_low_o,
   output logic                                 wake_req_o,
   output logic      [irq_pkg::VEC_NUM_W-1:0]   vector_num_o,
   output logic      [irq_pkg::VEC_ADDR_W-1:0]  vector_addr_o
);
   import irq_pkg::*;

   localparam int TOT = NSRC + NUM_EXT;

   gctrl_t                gctrl_ff;
   logic                  vec_en_ff;
   logic [VEC_ADDR_W-1:0] vtb_ff;
   logic [TOT-1:0]        flag_ff;
   logic [TOT-1:0]        enable_ff;
   logic [TOT-1:0]        prio_ff;
   logic [DATA_W-1:0]     rdata_ff;
   logic                  irq_high_ff;
   logic                  irq_low_ff;
   logic [VEC_NUM_W-1:0]  vec_num_ff;
   logic [VEC_ADDR_W-1:0] vec_addr_ff;
   logic [NUM_EXT-1:0]    ext_hit;

   vec_route_if #(.TOT(TOT)) route ();

   // External pins: synchronise and detect the chosen edge.

   pin_edge_detect #(.WIDTH(NUM_EXT)) u_edge (
      .clk_i      (clk_i),
      .rst_b_i    (rst_b_i),
      .pin_i      (ext_irq_pin_i),
      .rise_sel_i (gctrl_ff.ext_irq_edge_select),
      .hit_o      (ext_hit)
   );

   vector_resolve u_resolve (
      .rt (route.resolver)
   );

   // Register decode.

   wire wr_gctrl   = reg_wr_i && (reg_addr_i == GLOBAL_CONTROL_ADDR);
   wire wr_vctrl   = reg_wr_i && (reg_addr_i == VECTOR_CONTROL_ADDR);
   wire wr_vtb_l   = reg_wr_i && (reg_addr_i == VTB_LOW_ADDR);
   wire wr_vtb_h   = reg_wr_i && (reg_addr_i == VTB_HIGH_ADDR);
   wire wr_vtb_u   = reg_wr_i && (reg_addr_i == VTB_UPPER_ADDR);
   wire wr_ext_flg = reg_wr_i && (reg_addr_i == EXT_FLAG_ADDR);
   wire wr_ext_en  = reg_wr_i && (reg_addr_i == EXT_ENABLE_ADDR);
   wire wr_ext_pr  = reg_wr_i && (reg_addr_i == EXT_PRIO_ADDR);
   wire wr_src_flg = reg_wr_i && (reg_addr_i == SRC_FLAG_ADDR);
   wire wr_src_en  = reg_wr_i && (reg_addr_i == SRC_ENABLE_ADDR);
   wire wr_src_pr  = reg_wr_i && (reg_addr_i == SRC_PRIO_ADDR);

   wire [TOT-1:0] wdata_spread = {reg_wdata_i[NSRC-1:0], reg_wdata_i[NUM_EXT-1:0]};
   wire [TOT-1:0] flag_wmask   = {{NSRC{wr_src_flg}}, {NUM_EXT{wr_ext_flg}}};
   wire [TOT-1:0] enable_wmask = {{NSRC{wr_src_en}}, {NUM_EXT{wr_ext_en}}};
   wire [TOT-1:0] prio_wmask   = {{NSRC{wr_src_pr}}, {NUM_EXT{wr_ext_pr}}};

   // Flags: hardware events win over a software write in the same cycle.

   wire [TOT-1:0] set_evt  = {src_event_i, ext_hit};
   wire [TOT-1:0] nxt_flag = (flag_ff & ~flag_wmask)
                           | (wdata_spread & flag_wmask)
                           | set_evt;
   wire [TOT-1:0] nxt_enable = (enable_ff & ~enable_wmask)
                             | (wdata_spread & enable_wmask);
   wire [TOT-1:0] nxt_prio   = (prio_ff & ~prio_wmask)
                             | (wdata_spread & prio_wmask);

   wire [DATA_W-1:0] wdata_gctrl = reg_wdata_i & ~DATA_W'({2'b11, NUM_EXT'(0)});
   wire [VEC_ADDR_W-1:0] nxt_vtb = {
      wr_vtb_u ? reg_wdata_i[VEC_ADDR_W-2*DATA_W-1:0]
               : vtb_ff[VEC_ADDR_W-1:2*DATA_W],
      wr_vtb_h ? reg_wdata_i : vtb_ff[2*DATA_W-1:DATA_W],
      wr_vtb_l ? reg_wdata_i : vtb_ff[DATA_W-1:0]
   };

   // Request qualification.

   wire           ple       = gctrl_ff.priority_levels_enable;
   wire           ghe       = gctrl_ff.global_high_enable;
   wire           gle       = gctrl_ff.global_low_enable;
   wire [TOT-1:0] pend      = flag_ff & enable_ff;
   wire [TOT-1:0] as_high   = prio_ff | {TOT{~ple}};
   wire [TOT-1:0] high_req  = pend & as_high;
   wire [TOT-1:0] low_req   = pend & ~as_high;
   wire           nxt_high  = ghe && (|high_req);
   wire           nxt_low   = ghe && gle && ple && (|low_req);

   assign route.high_req = high_req;
   assign route.low_req  = low_req;
   assign route.vec_en   = vec_en_ff;
   assign route.prio_en  = ple;
   assign route.base     = vtb_ff;

   // Wake request: pure gates from stored state, so it holds with clocks stopped.

   assign wake_req_o = |pend;

   // Read selection.

   gctrl_t  gctrl_rd;
   status_t status_rd;

   always_comb begin
      gctrl_rd = gctrl_ff;
      gctrl_rd.global_low_enable = gle && ple;
      gctrl_rd.unused = '0;
      status_rd = '0;
      status_rd.high = irq_high_ff;
      status_rd.low  = irq_low_ff;
      status_rd.wake = wake_req_o;
   end

   wire [DATA_W-1:0] rd_value =
      (reg_addr_i == GLOBAL_CONTROL_ADDR) ? gctrl_rd :
      (reg_addr_i == VECTOR_CONTROL_ADDR) ? DATA_W'(vec_en_ff) :
      (reg_addr_i == VTB_LOW_ADDR)        ? vtb_ff[DATA_W-1:0] :
      (reg_addr_i == VTB_HIGH_ADDR)       ? vtb_ff[2*DATA_W-1:DATA_W] :
      (reg_addr_i == VTB_UPPER_ADDR)      ? DATA_W'(vtb_ff[VEC_ADDR_W-1:2*DATA_W]) :
      (reg_addr_i == IRQ_STATUS_ADDR)     ? status_rd :
      (reg_addr_i == VECTOR_NUM_ADDR)     ? DATA_W'(vec_num_ff) :
      (reg_addr_i == EXT_FLAG_ADDR)       ? DATA_W'(flag_ff[NUM_EXT-1:0]) :
      (reg_addr_i == EXT_ENABLE_ADDR)     ? DATA_W'(enable_ff[NUM_EXT-1:0]) :
      (reg_addr_i == EXT_PRIO_ADDR)       ? DATA_W'(prio_ff[NUM_EXT-1:0]) :
      (reg_addr_i == SRC_FLAG_ADDR)       ? DATA_W'(flag_ff[TOT-1:NUM_EXT]) :
      (reg_addr_i == SRC_ENABLE_ADDR)     ? DATA_W'(enable_ff[TOT-1:NUM_EXT]) :
      (reg_addr_i == SRC_PRIO_ADDR)       ? DATA_W'(prio_ff[TOT-1:NUM_EXT]) :
      '0;

   // Registers.

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gctrl_ff  <= GCTRL_RESET;
         vec_en_ff <= 1'b0;
         vtb_ff    <= VTB_RESET;
         flag_ff   <= '0;
         enable_ff <= '0;
         prio_ff   <= '1;
      end else begin
         if (wr_gctrl) begin
            gctrl_ff <= wdata_gctrl;
         end
         if (wr_vctrl) begin
            vec_en_ff <= reg_wdata_i[0];
         end
         vtb_ff    <= nxt_vtb;
         flag_ff   <= nxt_flag;
         enable_ff <= nxt_enable;
         prio_ff   <= nxt_prio;
      end
   end

   // Requests and vector to the core; the vector only follows live requests.

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_high_ff <= 1'b0;
         irq_low_ff  <= 1'b0;
         vec_num_ff  <= '0;
         vec_addr_ff <= LEGACY_HIGH_VEC;
         rdata_ff    <= '0;
      end else begin
         irq_high_ff <= nxt_high;
         irq_low_ff  <= nxt_low;
         if (nxt_high || nxt_low) begin
            vec_num_ff  <= route.num;
            vec_addr_ff <= route.addr;
         end
         rdata_ff <= reg_rd_i ? rd_value : '0;
      end
   end

   assign irq_high_o    = irq_high_ff;
   assign irq_low_o     = irq_low_ff;
   assign vector_num_o  = vec_num_ff;
   assign vector_addr_o = vec_addr_ff;
   assign reg_rdata_o   = rdata_ff;

   // Checks.

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_edge_sets_flag:
      assert property (ext_hit[0] |=> flag_ff[0])
      else $error("Pin edge did not set its flag.");

   a_flag_holds:
      assert property (flag_ff[1] && !wr_ext_flg |=> flag_ff[1])
      else $error("Flag cleared without a software write.");

   a_masked_quiet:
      assert property (pend == '0 |=> !irq_high_o && !irq_low_o)
      else $error("Request raised with no enabled flag.");

   a_high_gate:
      assert property (irq_high_o |-> $past(ghe) && $past(|high_req))
      else $error("High request without its global enable.");

   a_low_gate:
      assert property (!ghe || !gle |=> !irq_low_o)
      else $error("Low request while a global enable is clear.");

   a_no_prio_low:
      assert property (!ple [*2] |-> !irq_low_o)
      else $error("Low request while priority levels are off.");

   a_wake_ungated:
      assert property (enable_ff[2] && flag_ff[2] && !ghe |-> wake_req_o)
      else $error("Wake request gated by global enable.");

   a_wake_follows:
      assert property (enable_ff[0] && ext_hit[0] |=> wake_req_o)
      else $error("Enabled pin event did not wake.");

   a_legacy_vector:
      assert property (!vec_en_ff && !ple && nxt_high |=> vector_addr_o == LEGACY_HIGH_VEC)
      else $error("Legacy vector address not 0008h.");

   a_low_read_zero:
      assert property (reg_rd_i && reg_addr_i == GLOBAL_CONTROL_ADDR && !ple
                       |=> reg_rdata_o[6] == 1'b0)
      else $error("Low enable read back while priority is off.");

   a_rdata_once:
      assert property (!reg_rd_i |=> reg_rdata_o == '0)
      else $error("Read data present outside the read cycle.");

endmodule

// File: src/irq_pkg.sv
package irq_pkg;

   localparam int NUM_EXT    = 3;
   localparam int ADDR_W     = 12;
   localparam int DATA_W     = 8;
   localparam int VEC_ADDR_W = 21;
   localparam int VEC_NUM_W  = 4;
   localparam int VEC_SHIFT  = 1;

   localparam logic [ADDR_W-1:0] GLOBAL_CONTROL_ADDR = 12'h4d6;
   localparam logic [ADDR_W-1:0] VECTOR_CONTROL_ADDR = 12'h4d8;
   localparam logic [ADDR_W-1:0] VTB_LOW_ADDR        = 12'h4d9;
   localparam logic [ADDR_W-1:0] VTB_HIGH_ADDR       = 12'h4da;
   localparam logic [ADDR_W-1:0] VTB_UPPER_ADDR      = 12'h4db;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR     = 12'h4dc;
   localparam logic [ADDR_W-1:0] VECTOR_NUM_ADDR     = 12'h4dd;
   localparam logic [ADDR_W-1:0] EXT_FLAG_ADDR       = 12'h4a0;
   localparam logic [ADDR_W-1:0] EXT_ENABLE_ADDR     = 12'h4a1;
   localparam logic [ADDR_W-1:0] EXT_PRIO_ADDR       = 12'h4a2;
   localparam logic [ADDR_W-1:0] SRC_FLAG_ADDR       = 12'h4a3;
   localparam logic [ADDR_W-1:0] SRC_ENABLE_ADDR     = 12'h4a4;
   localparam logic [ADDR_W-1:0] SRC_PRIO_ADDR       = 12'h4a5;

   typedef struct packed {
      logic                global_high_enable;
      logic                global_low_enable;
      logic                priority_levels_enable;
      logic [1:0]          unused;
      logic [NUM_EXT-1:0]  ext_irq_edge_select;
   } gctrl_t;

   typedef struct packed {
      logic [4:0] unused;
      logic       wake;
      logic       low;
      logic       high;
   } status_t;

   localparam logic [DATA_W-1:0]     GCTRL_RESET     = 8'h07;
   localparam logic [VEC_ADDR_W-1:0] VTB_RESET       = 21'h000008;
   localparam logic [VEC_ADDR_W-1:0] LEGACY_HIGH_VEC = 21'h000008;
   localparam logic [VEC_ADDR_W-1:0] LEGACY_LOW_VEC  = 21'h000018;

endpackage

// File: src/vec_route_if.sv
`timescale 1ns/1ns
interface vec_route_if #(parameter int TOT = 11);
   import irq_pkg::*;
   logic [TOT-1:0]        high_req;
   logic [TOT-1:0]        low_req;
   logic                  vec_en;
   logic                  prio_en;
   logic [VEC_ADDR_W-1:0] base;
   logic                  is_high;
   logic [VEC_NUM_W-1:0]  num;
   logic [VEC_ADDR_W-1:0] addr;
   modport ctrl (output high_req, low_req, vec_en, prio_en, base,
                 input is_high, num, addr);
   modport resolver (input high_req, low_req, vec_en, prio_en, base,
                     output is_high, num, addr);
endinterface

// File: src/pin_edge_detect.sv
`timescale 1ns/1ns
module pin_edge_detect #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] pin_i,
   input  wire logic [WIDTH-1:0] rise_sel_i,
   output logic      [WIDTH-1:0] hit_o
);
   // The first valid sample after reset only primes the old level.
   for (genvar g = 0; g < WIDTH; g++) begin : g_pin
      logic s1_ff, s2_ff, s3_ff, prev_ff, primed_ff;
      wire  stable = (s2_ff == s3_ff);
      wire  change = stable && primed_ff && (s2_ff != prev_ff);
      assign hit_o[g] = change && (s2_ff == rise_sel_i[g]);
      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            s1_ff     <= 1'b0;
            s2_ff     <= 1'b0;
            s3_ff     <= 1'b0;
            prev_ff   <= 1'b0;
            primed_ff <= 1'b0;
         end else begin
            s1_ff <= pin_i[g];
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (stable) begin
               prev_ff   <= s2_ff;
               primed_ff <= 1'b1;
            end
         end
      end
   end
endmodule

// File: src/vector_resolve.sv
`timescale 1ns/1ns
module vector_resolve (
   vec_route_if.resolver rt
);
   import irq_pkg::*;
   localparam int TOT = $bits(rt.high_req);

   wire            any_high = |rt.high_req;
   wire  [TOT-1:0] pick     = any_high ? rt.high_req : rt.low_req;
   logic [VEC_NUM_W-1:0] num;

   // Lowest source index wins within the chosen level.
   always_comb begin
      num = '0;
      for (int i = TOT - 1; i >= 0; i--) begin
         if (pick[i]) begin
            num = VEC_NUM_W'(i);
         end
      end
   end

   wire [VEC_ADDR_W-1:0] entry  = VEC_ADDR_W'(num) << VEC_SHIFT;
   wire [VEC_ADDR_W-1:0] legacy = rt.is_high ? LEGACY_HIGH_VEC : LEGACY_LOW_VEC;

   assign rt.is_high = any_high || !rt.prio_en;
   assign rt.num     = num;
   // Without vectoring the table is bypassed and its order is irrelevant.
   assign rt.addr    = rt.vec_en ? rt.base + entry : legacy;
endmodule

// File: bench/cpu_core_model.sv
`timescale 1ns/1ns
module cpu_core_model (
   input  wire logic                           clk_i,
   input  wire logic                           rst_b_i,
   input  wire logic                           irq_high_i,
   input  wire logic                           irq_low_i,
   input  wire logic [irq_pkg::VEC_ADDR_W-1:0] vector_addr_i,
   output logic      [irq_pkg::VEC_ADDR_W-1:0] fetch_addr_o
);
   import irq_pkg::*;
   logic req_d_ff;
   wire  req = irq_high_i | irq_low_i;

   // The core branches only when a request is raised, never on a bare wake.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         req_d_ff     <= 1'b0;
         fetch_addr_o <= '0;
      end else begin
         req_d_ff <= req;
         if (req && !req_d_ff) begin
            fetch_addr_o <= vector_addr_i;
         end
      end
   end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import irq_pkg::*;
   logic                  clk_i;
   logic                  rst_b_i;
   logic [ADDR_W-1:0]     reg_addr_i;
   logic [DATA_W-1:0]     reg_wdata_i;
   logic                  reg_wr_i;
   logic                  reg_rd_i;
   logic [DATA_W-1:0]     reg_rdata_o;
   logic [NUM_EXT-1:0]    ext_irq_pin_i;
   logic                  irq_high_o;
   logic                  irq_low_o;
   logic                  wake_req_o;
   logic [VEC_ADDR_W-1:0] vector_addr_o;
   logic [VEC_NUM_W-1:0]  vector_num;
   logic [VEC_ADDR_W-1:0] fetch_addr;
   int                    mismatches;
   int                    n_compared;

   interrupt_enable_priority_wake dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .ext_irq_pin_i(ext_irq_pin_i), .src_event_i(8'h00), .irq_high_o(irq_high_o),
      .irq_low_o(irq_low_o), .wake_req_o(wake_req_o), .vector_num_o(vector_num),
      .vector_addr_o(vector_addr_o));

   cpu_core_model core (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .irq_high_i(irq_high_o), .irq_low_i(irq_low_o),
      .vector_addr_i(vector_addr_o), .fetch_addr_o(fetch_addr));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t register read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_sig(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t output %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      chk_reg(reg_rdata_o, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic pin(input int i, input logic v);
      @(posedge clk_i);
      ext_irq_pin_i[i] <= v;
      settle(8);
   endtask

   task automatic outs(input logic h, input logic l, input logic w);
      chk_sig({21'h0, irq_high_o, irq_low_o, wake_req_o}, {21'h0, h, l, w});
   endtask

   task automatic t_reset;
      chk_sig(vector_addr_o, 24'h000008);
      rd(GLOBAL_CONTROL_ADDR, 8'h07);
      rd(VTB_LOW_ADDR, 8'h08);
      rd(VTB_HIGH_ADDR, 8'h00);
      rd(VTB_UPPER_ADDR, 8'h00);
      rd(EXT_PRIO_ADDR, 8'h07);
      rd(SRC_PRIO_ADDR, 8'hff);
      wr(GLOBAL_CONTROL_ADDR, 8'hff);
      rd(GLOBAL_CONTROL_ADDR, 8'he7);
      wr(12'h000, 8'h5a);
      rd(12'h000, 8'h00);
   endtask

   task automatic t_edges;
      wr(EXT_FLAG_ADDR, 8'h00);
      wr(EXT_ENABLE_ADDR, 8'h01);
      wr(GLOBAL_CONTROL_ADDR, 8'h81);
      pin(0, 1'b1);
      rd(EXT_FLAG_ADDR, 8'h01);
      outs(1'b1, 1'b0, 1'b1);
      chk_sig(fetch_addr, 24'h000008);
      wr(GLOBAL_CONTROL_ADDR, 8'h01);
      settle(3);
      outs(1'b0, 1'b0, 1'b1);
      wr(EXT_FLAG_ADDR, 8'h00);
      pin(0, 1'b0);
      rd(EXT_FLAG_ADDR, 8'h00);
      wr(GLOBAL_CONTROL_ADDR, 8'h80);
      pin(0, 1'b1);
      rd(EXT_FLAG_ADDR, 8'h00);
      pin(0, 1'b0);
      rd(EXT_FLAG_ADDR, 8'h01);
      wr(EXT_FLAG_ADDR, 8'h00);
   endtask

   task automatic t_disabled;
      wr(EXT_ENABLE_ADDR, 8'h00);
      wr(GLOBAL_CONTROL_ADDR, 8'h82);
      pin(1, 1'b1);
      rd(EXT_FLAG_ADDR, 8'h02);
      outs(1'b0, 1'b0, 1'b0);
      wr(EXT_FLAG_ADDR, 8'h00);
   endtask

   task automatic t_prio;
      wr(EXT_ENABLE_ADDR, 8'h07);
      wr(EXT_PRIO_ADDR, 8'h06);
      wr(GLOBAL_CONTROL_ADDR, 8'ha1);
      pin(0, 1'b1);
      outs(1'b0, 1'b0, 1'b1);
      wr(GLOBAL_CONTROL_ADDR, 8'he1);
      settle(3);
      outs(1'b0, 1'b1, 1'b1);
      chk_sig(vector_addr_o, 24'h000018);
      wr(GLOBAL_CONTROL_ADDR, 8'h61);
      settle(3);
      outs(1'b0, 1'b0, 1'b1);
      rd(GLOBAL_CONTROL_ADDR, 8'h61);
      wr(GLOBAL_CONTROL_ADDR, 8'h81);
      settle(3);
      outs(1'b1, 1'b0, 1'b1);
      wr(EXT_FLAG_ADDR, 8'h00);
   endtask

   task automatic t_vector;
      wr(VECTOR_CONTROL_ADDR, 8'h01);
      wr(VTB_LOW_ADDR, 8'h00);
      wr(VTB_HIGH_ADDR, 8'h3f);
      wr(VTB_UPPER_ADDR, 8'h00);
      rd(VTB_HIGH_ADDR, 8'h3f);
      wr(EXT_FLAG_ADDR, 8'h04);
      settle(4);
      chk_sig(vector_addr_o, 24'h003f04);
      chk_sig(fetch_addr, 24'h003f04);
      chk_sig(24'(vector_num), 24'h000002);
      wr(EXT_FLAG_ADDR, 8'h00);
   endtask

   initial begin
      rst_b_i       = 1'b0;
      reg_addr_i    = '0;
      reg_wdata_i   = '0;
      reg_wr_i      = 1'b0;
      reg_rd_i      = 1'b0;
      ext_irq_pin_i = '0;
      mismatches    = 0;
      n_compared    = 0;
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1'b1;
      settle(4);
      t_reset();
      t_edges();
      t_disabled();
      t_prio();
      t_vector();
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      conclude();
   end
endmodule
